//--- hdl/bsr_top.sv
// Bidirectional shift register: four 8-bit bytes, trigger-edge shifting, one selected output.
// Assumes trigger, serial input and direction come from pins (synchronised here), APB on clk.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "bsr_map.svh"
module bsr_top
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic power_restore,
    input wire logic shift_trigger,
    input wire logic serial_in,
    input wire logic shift_dir,
    output logic shift_out,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic trg_prev;
    logic restore_prev;
    wire [3:0] pins_now = {power_restore, shift_dir, serial_in, shift_trigger};
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync_a <= 4'h0;
        end
        else if (clk_en)
        begin
            sync_a <= pins_now;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sync_b <= 4'h0;
        end
        else if (clk_en)
        begin
            sync_b <= sync_a;
        end
    end

    wire trg_s = sync_b[0];
    wire din_s = sync_b[1];
    wire dir_s = sync_b[2];
    wire restore_s = sync_b[3];

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    // Both previous values reset to the idle pin level, so no false edge
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            trg_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            trg_prev <= trg_s;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            restore_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            restore_prev <= restore_s;
        end
    end

    wire trg_rise = trg_s & ~trg_prev;
    wire restore_rise = restore_s & ~restore_prev;

    // ------------------------------------------------------------
    // Direction decode
    // ------------------------------------------------------------
    bsr_pkg::bsr_dir_t dir_now;
    assign dir_now = dir_s ? bsr_pkg::BSR_DOWN : bsr_pkg::BSR_UP;

    // ------------------------------------------------------------
    // Configuration and storage
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic [7:0] sreg [`BSR_NBYTES];
    logic [7:0] shift_cnt;
    logic [7:0] next_shift_cnt;
    logic rd_wait;
    logic next_rd_wait;
    logic [31:0] next_prdata;
    logic next_shift_out;
    wire [1:0] cfg_byte = ctrl[`BSR_CTRL_BYTE_MSB:`BSR_CTRL_BYTE_LSB];
    wire [2:0] cfg_bit = ctrl[`BSR_CTRL_BIT_MSB:`BSR_CTRL_BIT_LSB];
    wire cfg_ret = ctrl[`BSR_CTRL_RET];
    // Power restore without retention wipes contents; retention keeps all bytes
    wire wipe = restore_rise & ~cfg_ret;

    // ------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------
    wire [7:0] cur_byte = sreg[cfg_byte];
    wire [7:0] up_val = {cur_byte[6:0], din_s};
    wire [7:0] down_val = {din_s, cur_byte[7:1]};
    wire [7:0] next_byte = (dir_now == bsr_pkg::BSR_DOWN) ? down_val : up_val;
    wire do_shift = trg_rise & ~wipe;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire acc = psel & penable;
    wire rd_acc = acc & ~pwrite;
    wire hit_ctrl = (paddr == `BSR_OFF_CTRL);
    wire hit_data = (paddr == `BSR_OFF_DATA);
    wire hit_stat = (paddr == `BSR_OFF_STAT);
    wire hit_any = hit_ctrl | hit_data | hit_stat;
    // Reads take one wait state so that prdata comes from a flip-flop
    assign pready = acc & clk_en & (pwrite | rd_wait);
    assign pslverr = pready & ~hit_any;

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    // A data write yields to a shift or a wipe in the same cycle
    wire wr_ctrl = pready & pwrite & hit_ctrl;
    wire wr_data = pready & pwrite & hit_data & ~do_shift & ~wipe;

    // ------------------------------------------------------------
    // Status and data words
    // ------------------------------------------------------------
    wire [31:0] data_word = {sreg[3], sreg[2], sreg[1], sreg[0]};
    wire [31:0] stat_word = {16'h0000, shift_cnt, 7'h00, shift_out};

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
        begin
            rd_mux = ctrl;
        end
        else if (hit_data)
        begin
            rd_mux = data_word;
        end
        else if (hit_stat)
        begin
            rd_mux = stat_word;
        end
    end

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    assign next_ctrl = wr_ctrl ? pwdata : ctrl;
    assign next_rd_wait = rd_acc & ~rd_wait;
    assign next_prdata = (rd_acc & ~rd_wait) ? rd_mux : prdata;
    assign next_shift_cnt = do_shift ? shift_cnt + 8'h01 : shift_cnt;
    assign next_shift_out = cur_byte[cfg_bit];

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl <= `BSR_CTRL_RESET;
        end
        else if (clk_en)
        begin
            ctrl <= next_ctrl;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rd_wait <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_wait <= next_rd_wait;
        end
    end

    // ------------------------------------------------------------
    // Shift counter
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            shift_cnt <= 8'h00;
        end
        else if (clk_en)
        begin
            shift_cnt <= next_shift_cnt;
        end
    end

    // ------------------------------------------------------------
    // Storage bytes
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `BSR_NBYTES; gi++)
        begin : g_byte
            wire sel_byte = (cfg_byte == 2'(gi));
            wire [7:0] wr_byte = pwdata[gi*8 +: 8];
            logic [7:0] next_sreg;
            always_comb
            begin
                next_sreg = sreg[gi];
                if (wipe)
                begin
                    next_sreg = 8'h00;
                end
                else if (do_shift & sel_byte)
                begin
                    next_sreg = next_byte;
                end
                else if (wr_data)
                begin
                    next_sreg = wr_byte;
                end
            end
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    sreg[gi] <= 8'h00;
                end
                else if (clk_en)
                begin
                    sreg[gi] <= next_sreg;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Output
    // ------------------------------------------------------------
    // Output trails storage by one cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            shift_out <= 1'b0;
        end
        else if (clk_en)
        begin
            shift_out <= next_shift_out;
        end
    end
endmodule

//--- pkg/bsr_map.svh
// Constants for the bidirectional shift register block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the design file.
`ifndef BSR_MAP_SVH
`define BSR_MAP_SVH
`define BSR_OFF_CTRL 12'h000
`define BSR_OFF_DATA 12'h004
`define BSR_OFF_STAT 12'h008
`define BSR_CTRL_BYTE_LSB 0
`define BSR_CTRL_BYTE_MSB 1
`define BSR_CTRL_BIT_LSB 4
`define BSR_CTRL_BIT_MSB 6
`define BSR_CTRL_RET 8
`define BSR_CTRL_RESET 32'h0000_0000
`define BSR_DATA_RESET 32'h0000_0000
`define BSR_NBYTES 4
`define BSR_STAT_OUT 0
`define BSR_STAT_CNT_LSB 8
`define BSR_STAT_CNT_MSB 15
`endif

//--- pkg/bsr_pkg.sv
// Types for the bidirectional shift register block.
// Assumes the map header sits beside it on the include path.
package bsr_pkg;
`include "bsr_map.svh"
    typedef enum logic [1:0]
    {
        BSR_UP = 2'b01,
        BSR_DOWN = 2'b10
    } bsr_dir_t;
endpackage

//--- verification/bsr_monitor.sv
// Port checks for bsr_top, bound at the foot of this file.
// Assumes CTRL at 12'h000 and DATA at 12'h004; a transfer ends when pready is high.
`timescale 1ns/1ps
module bsr_monitor
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic power_restore,
    input wire logic shift_trigger,
    input wire logic serial_in,
    input wire logic shift_dir,
    input wire logic shift_out,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata
);
    logic [8:0] cfg;
    wire acc = psel && penable && pready;
    wire dbit = pwdata[{cfg[1:0], cfg[6:4]}];
    always_ff @(posedge clk)
        cfg <= sys_rst ? 9'h000 : (acc && pwrite && paddr == 12'h000) ? pwdata[8:0] : cfg;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_entry_up: assert property ($rose(shift_trigger) && !shift_dir && cfg[6:4] == 3'h0
        |-> ##[4:7] shift_out == serial_in) else $error("up entry bit wrong");
    a_entry_down: assert property ($rose(shift_trigger) && shift_dir && cfg[6:4] == 3'h7
        |-> ##[4:7] shift_out == serial_in) else $error("down entry bit wrong");
    a_fall_quiet: assert property ($fell(shift_trigger) ##1 (!psel && !shift_trigger)[*7]
        |-> shift_out == $past(shift_out, 7)) else $error("output moved after falling edge");
    a_wipe_zero: assert property ($rose(power_restore) && !cfg[8]
        |-> ##8 !shift_out) else $error("bits not cleared on restart");
    a_keep_bits: assert property ($rose(power_restore) && cfg[8]
        |-> ##8 shift_out == $past(shift_out, 8)) else $error("retained bit lost");
    a_data_out: assert property (acc && pwrite && paddr == 12'h004
        |-> ##2 shift_out == $past(dbit, 2)) else $error("output not the selected bit");
    a_bad_addr: assert property (acc && paddr > 12'h008
        |-> pslverr) else $error("unmapped access accepted");
    a_good_addr: assert property (acc && paddr == 12'h004
        |-> !pslverr) else $error("data word access refused");
endmodule
bind bsr_top bsr_monitor u_mon (.*);

//--- verification/bsr_prog.sv
// Program-logic model: drives the trigger, data bit and direction pins.
// Assumes go lasts one cycle and comes only after the last frame ended.
`timescale 1ns/1ps
module bsr_prog
(
    input wire logic clk,
    input wire logic go,
    input wire logic bv,
    input wire logic dr,
    output logic shift_trigger,
    output logic serial_in = 1'b0,
    output logic shift_dir = 1'b0
);
    logic [3:0] cnt = 4'h0;
    // Frame: trigger high four cycles, low four; data inverts once it ends
    assign shift_trigger = cnt > 4'h4;
    always @(posedge clk)
    begin
        cnt <= go ? 4'h8 : cnt - {3'h0, cnt != 4'h0};
        serial_in <= go ? bv : serial_in ^ (cnt == 4'h1);
        shift_dir <= go ? dr : shift_dir;
    end
endmodule

//--- verification/bsr_tb_top.sv
// Self-checking bench for bsr_top: APB tasks, program model, power pin.
// Assumes bsr_prog and the bound bsr_monitor are compiled with it.
`timescale 1ns/1ps
module bsr_tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, power_restore = 1'b0, go = 1'b0, bv = 1'b0, dr = 1'b0;
    logic clk_en = 1'b1, err;
    logic [7:0] nsh = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, shift_trigger, serial_in, shift_dir;
    logic shift_out, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, mdl = 32'ha5c3_1e87;
    int bad_count = 0, check_count = 0, cyc = 0;
    always #5 clk = ~clk;
    always @(posedge clk)
        if (++cyc > 3000)
            finish_test;
    bsr_top u_dut (.*);
    bsr_prog u_prog (.*);
    task chk(input string n, input logic [31:0] e, s);
        check_count++;
        bad_count += int'(s !== e);
        if (s !== e)
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge clk);
    endtask
    task t_sel;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h0, rd);
        apb(1'b1, 12'h004, mdl);
        apb(1'b0, 12'h00c, 32'h0);
        chk("err", 32'h1, {31'h0, err});
        for (int i = 0; i < 32; i++)
        begin
            apb(1'b1, 12'h000, {25'h0, i[2:0], 2'h0, i[4:3]});
            @(posedge clk);
            chk("out", {31'h0, mdl[i]}, {31'h0, shift_out});
        end
        $display("t_sel done");
    endtask
    task t_shift(input logic d, b);
        apb(1'b1, 12'h000, d ? 32'h71 : 32'h01);
        {go, dr, bv} <= {1'b1, d, b};
        @(posedge clk) go <= 1'b0;
        repeat (12) @(posedge clk);
        mdl[15:8] = d ? {b, mdl[15:9]} : {mdl[14:8], b};
        apb(1'b0, 12'h004, 32'h0);
        chk("data", mdl, rd);
        nsh = nsh + 8'h01;
        apb(1'b0, 12'h008, 32'h0);
        chk("stat", {16'h0, nsh, 7'h0, d ? mdl[15] : mdl[8]}, rd);
        $display("t_shift done");
    endtask
    task t_power(input logic r);
        apb(1'b1, 12'h000, {23'h0, r, 8'h11});
        power_restore <= 1'b1;
        repeat (12) @(posedge clk);
        mdl = r ? mdl : 32'h0;
        apb(1'b0, 12'h004, 32'h0);
        power_restore <= 1'b0;
        chk("data", mdl, rd);
        $display("t_power done");
    endtask
    task finish_test;
        bad_count += int'(cyc > 3000);
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_sel;
        t_shift(1'b0, 1'b1);
        t_shift(1'b1, 1'b0);
        t_power(1'b1);
        t_power(1'b0);
        finish_test;
    end
endmodule
